/* common/supervisor_pkg.sv */
/*
 * constants for the burst and overload supervisor: timing figures, counter
 * widths and the supervisor state type.
 * assumes a 10 MHz system clock and a switching-cycle pulse from the oscillator.
 */
// How it works
// - comp low: switch off, enter idle
// - exit burst above threshold plus hysteresis
// - burst mode selects reduced current limit
// - count up on limit, down otherwise
// - counter at trip count disables turn-on
// - after trip wait, then soft start
// - stop time fixed, independent of count
// - trip and retry repeat while overloaded
// - limit gone: count down, keep switching
// - open loop: peak limit and clamp current
// - soft start ramps limit, every start
// - fault stops switching, supply recharges
package supervisor_pkg;
    // overload trip time in switching cycles
    localparam int unsigned OVL_CYCLES     = 1024;
    localparam int unsigned OVL_W          = 11;
    // retry delay in microseconds and its clock count
    localparam int unsigned RESTART_US     = 1000;
    localparam int unsigned CLK_MHZ        = 10;
    localparam int unsigned RESTART_CLKS   = RESTART_US * CLK_MHZ;
    localparam int unsigned RESTART_W      = 24;
    // soft start duration in microseconds and its clock count
    localparam int unsigned SOFTSTART_US   = 8000;
    localparam int unsigned SOFTSTART_CLKS = SOFTSTART_US * CLK_MHZ;
    // ramp output width, limit code range
    localparam int unsigned RAMP_W         = 8;
    localparam logic [7:0]  RAMP_FULL      = 8'h00_FF;

    typedef enum logic [1:0] {
        ST_SOFTSTART,
        ST_RUN,
        ST_RETRY
    } sup_state_t;
endpackage : supervisor_pkg

/* dv/analog_front_model.sv */
/* far side model: comparators, current sense and oscillator tick.
   assumes the bench sets the analogue conditions as plain levels. */
`timescale 1ns/1ps
module analog_front_model (
    input  wire logic clock_i, gate_i, ovl_i, clamp_i, low_i, exit_i,
    output logic      tick_o, limit_o, clamp_o, below_o, above_o
);
    initial tick_o = 1'b0;
    // switching cycle of two clocks, changed off the sampling edge
    always @(negedge clock_i) tick_o <= !tick_o;
    // current reaches the limit only while the switch may turn on
    assign limit_o = ovl_i & gate_i;
    assign clamp_o = clamp_i;
    assign below_o = low_i;
    assign above_o = exit_i;
endmodule : analog_front_model

/* dv/supervisor_props.sv */
/* assertions on the supervisor top ports, bound at the foot of this file.
   assumes the 2-flop input sync plus one output flop of the hand-over. */
`timescale 1ns/1ps
module supervisor_props (
    // clock, reset and inputs
    input wire logic clock_i, rst_i, cycle_tick_i, comp_below_low_i, comp_above_exit_i,
    input wire logic limit_hit_i, clamp_over_i,
    // outputs watched
    input wire logic gate_enable_o, burst_limit_sel_o, idle_low_power_o, hv_recharge_en_o,
    input wire logic open_loop_fault_o,
    input wire logic [supervisor_pkg::RAMP_W-1:0] limit_ramp_o
);
    logic [23:0] off_q; // clocks spent in retry
    logic [11:0] run_q; // ticks at the limit while switching
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // retry length, so the restart delay is pinned to a figure
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) off_q <= 24'h00_0000;
        else off_q <= hv_recharge_en_o ? off_q + 24'h00_0001 : 24'h00_0000;
    end
    // raw input leads the sync chain, so the bound carries two ticks of slack
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) run_q <= 12'h000;
        else if (!gate_enable_o) run_q <= 12'h000;
        else if (cycle_tick_i) run_q <= limit_hit_i ? run_q + 12'h001 : 12'h000;
    end
    chk_burst_gate_off: assert property (comp_below_low_i [*3] |=> !gate_enable_o)
        else $error("gate on while comp low");
    // limit select sits behind the burst flop as well: sync 2, burst 1, output 1
    chk_burst_limit_sel: assert property (comp_below_low_i [*3] |=> ##1 burst_limit_sel_o)
        else $error("burst limit not selected");
    // the exit level is seen four edges before idle is observed low
    chk_burst_exit_cause: assert property ($fell(idle_low_power_o) |->
        $past(comp_above_exit_i, 4)) else $error("burst left without exit level");
    chk_idle_gate_off: assert property (idle_low_power_o |-> !gate_enable_o)
        else $error("gate on in idle");
    chk_recharge_gate_off: assert property (hv_recharge_en_o |-> !gate_enable_o)
        else $error("recharge while switching");
    chk_open_loop_cause: assert property ($rose(open_loop_fault_o) |->
        $past(limit_hit_i, 3) && $past(clamp_over_i, 3)) else $error("open loop no cause");
    chk_open_loop_stop: assert property (open_loop_fault_o |->
        ##[0:2] (hv_recharge_en_o && !gate_enable_o)) else $error("open loop kept on");
    chk_trip_bound: assert property (run_q <= 12'h402)
        else $error("overload trip too late");
    chk_retry_length: assert property ($fell(hv_recharge_en_o) |->
        off_q >= 24'h00_2706 && off_q <= 24'h00_271A) else $error("retry delay wrong");
    cover property ($rose(idle_low_power_o));
    cover property ($fell(hv_recharge_en_o));
    cover property ($rose(open_loop_fault_o));
endmodule : supervisor_props

bind burst_overload_supervisor supervisor_props chk (.*);

/* dv/tb_burst_overload_supervisor.sv */
/* bench for the supervisor: burst, overload trip, retry, open loop.
   assumes the far side model and the bound checker. */
`timescale 1ns/1ps
module tb_burst_overload_supervisor;
    logic clock_i = 0, rst_i = 1, ovl = 0, clmp = 0, low = 0, ext = 0;
    logic cycle_tick_i, comp_below_low_i, comp_above_exit_i, limit_hit_i, clamp_over_i;
    logic gate_enable_o, burst_limit_sel_o, idle_low_power_o, hv_recharge_en_o;
    logic open_loop_fault_o;
    logic [supervisor_pkg::RAMP_W-1:0] limit_ramp_o;
    int n_errors = 0, n_tests = 0;
    always #50 clock_i = !clock_i;
    analog_front_model afm (.clock_i(clock_i), .gate_i(gate_enable_o), .ovl_i(ovl),
        .clamp_i(clmp), .low_i(low), .exit_i(ext), .tick_o(cycle_tick_i),
        .limit_o(limit_hit_i), .clamp_o(clamp_over_i), .below_o(comp_below_low_i),
        .above_o(comp_above_exit_i));
    burst_overload_supervisor uut (.*);
    task automatic check(string what, logic [16:0] seen, logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // bounded wait for the gate level; n returns clocks spent
    task automatic wait_gate(logic lvl, int lim, output int n);
        n = 0;
        while (gate_enable_o !== lvl && n < lim) begin
            @(negedge clock_i);
            n++;
        end
    endtask : wait_gate
    task automatic t_startup;
        int n;
        check("ramp", limit_ramp_o, 0);
        n = 0;
        while (limit_ramp_o !== 8'hFF && n < 85000) begin
            @(negedge clock_i);
            n++;
        end
        check("ramp time", n > 79000 && n < 85000, 1);
        check("gate", gate_enable_o, 1);
    endtask : t_startup
    task automatic t_burst;
        clmp = 1; // clamp alone is no fault
        low = 1;
        repeat (5) @(negedge clock_i);
        check("burst", {gate_enable_o, idle_low_power_o, burst_limit_sel_o}, 3);
        check("olf", open_loop_fault_o, 0);
        clmp = 0;
        low = 0;
        repeat (6) @(negedge clock_i);
        check("hysteresis", idle_low_power_o, 1);
        ext = 1;
        repeat (5) @(negedge clock_i);
        check("exit", {gate_enable_o, burst_limit_sel_o}, 2);
        ext = 0;
    endtask : t_burst
    task automatic t_overload;
        int n;
        ovl = 1; // 800 ticks up, then 1000 down to zero
        repeat (1600) @(negedge clock_i);
        check("olf no clamp", open_loop_fault_o, 0);
        ovl = 0;
        wait_gate(0, 2000, n);
        check("no stop", n, 2000);
        ovl = 1;
        wait_gate(0, 2200, n);
        check("trip", n >= 2040 && n <= 2060, 1);
        check("recharge", hv_recharge_en_o, 1);
    endtask : t_overload
    task automatic t_restart;
        int n;
        wait_gate(1, 10100, n);
        check("retry", n >= 9990 && n <= 10010, 1);
        check("fresh ramp", limit_ramp_o < 2, 1);
        clmp = 1; // overload still there, now with clamp current
        // the fault flag stands only until retry clears it, one edge after the stop
        repeat (4) @(negedge clock_i);
        check("olf stop", {open_loop_fault_o, gate_enable_o}, 2);
        ovl = 0;
        clmp = 0;
        wait_gate(1, 10100, n);
        check("olf retry", n >= 9985 && n <= 10010, 1);
    endtask : t_restart
    initial begin
        repeat (5) @(negedge clock_i);
        rst_i = 0;
        t_startup;
        t_burst;
        t_overload;
        t_restart;
        end_sim;
    end
    // watchdog well past the expected run
    initial begin
        repeat (115000) @(posedge clock_i);
        n_errors++;
        end_sim;
    end
endmodule : tb_burst_overload_supervisor

/* src/burst_overload_supervisor.sv */
/*
 * supervisor gating turn-on of the power switch: burst mode, overload
 * auto-restart, open-loop fault, soft-start ramp of the current limit.
 * assumes comparator flags arrive asynchronously from the analogue front end;
 * rst_i is the supply undervoltage reset.
 */
`timescale 1ns/1ps
module burst_overload_supervisor (
    // clock and reset
    input  wire logic                              clock_i,
    input  wire logic                              rst_i,
    // switching cycle pulse from the oscillator divider
    input  wire logic                              cycle_tick_i,
    // comparator flags (asynchronous)
    input  wire logic                              comp_below_low_i,   // below burst_low_threshold
    input  wire logic                              comp_above_exit_i,  // above low plus hysteresis
    input  wire logic                              limit_hit_i,        // peak current limit
    input  wire logic                              clamp_over_i,       // clamp over open-loop thr
    // outputs to power stage
    output logic                                   gate_enable_o,
    output logic                                   burst_limit_sel_o,
    output logic                                   idle_low_power_o,
    output logic                                   hv_recharge_en_o,
    output logic [supervisor_pkg::RAMP_W-1:0]      limit_ramp_o,
    output logic                                   open_loop_fault_o
);
    // two-flop synchronisers, first stage read only by second
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic       below_s;
    logic       above_s;
    logic       limit_s;
    logic       clamp_s;

    supervisor_pkg::sup_state_t state_q;      // supervisor state
    logic                       burst_q;      // burst idle active
    logic                       trip;         // overload trip from counter
    logic                       fault;        // any stopping fault
    logic [23:0]                timer_q;      // retry wait timer
    logic [23:0]                step_q;       // clocks per ramp step

    localparam logic [23:0] RETRY_END = 24'(supervisor_pkg::RESTART_CLKS - 1);
    localparam logic [23:0] STEP_END  =
        24'(supervisor_pkg::SOFTSTART_CLKS / supervisor_pkg::RAMP_FULL - 1);

    // synchronise comparator inputs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end else begin
            meta_q <= {clamp_over_i, limit_hit_i, comp_above_exit_i, comp_below_low_i};
            sync_q <= meta_q;
        end
    end
    assign below_s = sync_q[0];
    assign above_s = sync_q[1];
    assign limit_s = sync_q[2];
    assign clamp_s = sync_q[3];

    // open loop needs both peak limit and clamp current
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            open_loop_fault_o <= 1'b0;
        end else begin
            open_loop_fault_o <= limit_s && clamp_s && (state_q != supervisor_pkg::ST_RETRY);
        end
    end

    // per-cycle overload counter, cleared on trip
    overload_counter u_ovl (
        .clock_i      (clock_i),
        .rst_i        (rst_i),
        .cycle_tick_i (cycle_tick_i && (state_q != supervisor_pkg::ST_RETRY)),
        .limit_hit_i  (limit_s),
        .clear_i      (state_q == supervisor_pkg::ST_RETRY),
        .trip_o       (trip)
    );

    // open loop joins overload into the same restart path
    assign fault = trip || open_loop_fault_o;

    // burst hysteresis: enter below low, leave above low plus hysteresis
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            burst_q <= 1'b0;
        end else if (below_s) begin
            burst_q <= 1'b1;
        end else if (above_s) begin
            burst_q <= 1'b0;
        end
    end

    // supervisor sequence: soft start, run, retry wait
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q      <= supervisor_pkg::ST_SOFTSTART;
            timer_q      <= '0;
            step_q       <= '0;
            limit_ramp_o <= '0;
        end else begin
            unique case (state_q)
                supervisor_pkg::ST_SOFTSTART: begin
                    if (fault) begin
                        state_q <= supervisor_pkg::ST_RETRY;
                        timer_q <= '0;
                    end else if (limit_ramp_o == supervisor_pkg::RAMP_FULL) begin
                        state_q <= supervisor_pkg::ST_RUN;
                    end else if (step_q == STEP_END) begin
                        step_q       <= '0;
                        limit_ramp_o <= limit_ramp_o + 1'b1;
                    end else begin
                        step_q <= step_q + 1'b1;
                    end
                end
                supervisor_pkg::ST_RUN: begin
                    if (fault) begin
                        state_q <= supervisor_pkg::ST_RETRY;
                        timer_q <= '0;
                    end
                end
                supervisor_pkg::ST_RETRY: begin
                    // a fixed wait keeps restart attempts rare under overload
                    if (timer_q == RETRY_END) begin
                        state_q      <= supervisor_pkg::ST_SOFTSTART;
                        limit_ramp_o <= '0;
                        step_q       <= '0;
                    end else begin
                        timer_q <= timer_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // gate enable and supply control, all registered
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gate_enable_o     <= 1'b0;
            burst_limit_sel_o <= 1'b0;
            idle_low_power_o  <= 1'b0;
            hv_recharge_en_o  <= 1'b0;
        end else begin
            gate_enable_o     <= (state_q != supervisor_pkg::ST_RETRY) && !burst_q
                                 && !fault && !below_s;
            burst_limit_sel_o <= burst_q;
            idle_low_power_o  <= burst_q;
            hv_recharge_en_o  <= (state_q == supervisor_pkg::ST_RETRY) || fault;
        end
    end
endmodule : burst_overload_supervisor

/* src/overload_counter.sv */
/*
 * up-down overload counter, advanced once per switching cycle.
 * assumes limit_hit_i is same-domain and valid at cycle_tick_i.
 */
`timescale 1ns/1ps
module overload_counter (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // control
    input  wire logic cycle_tick_i,   // one pulse per switching cycle
    input  wire logic limit_hit_i,    // current limit seen this cycle
    input  wire logic clear_i,        // clear on trip
    // status
    output logic      trip_o          // count reached the trip figure
);
    localparam logic [supervisor_pkg::OVL_W-1:0] TRIP_COUNT =
        supervisor_pkg::OVL_W'(supervisor_pkg::OVL_CYCLES);
    logic [supervisor_pkg::OVL_W-1:0] count_q;  // current count

    // count up on limit, down to zero otherwise
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= '0;
        end else if (clear_i) begin
            count_q <= '0;
        end else if (cycle_tick_i) begin
            if (limit_hit_i) begin
                if (count_q != TRIP_COUNT) begin
                    count_q <= count_q + 1'b1;
                end
            end else if (count_q != '0) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // trip flag; onset from a nonzero count trips sooner
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            trip_o <= 1'b0;
        end else begin
            trip_o <= (count_q == TRIP_COUNT) && !clear_i;
        end
    end
endmodule : overload_counter
